// File: design/mctir_regs.sv
// Configuration, identification and temperature interrupt registers behind the 2-wire port.
`timescale 1ns/1ns
// Summary of operation
// - Identification low nibble reads live pins.
// - Bits 5:4 select first fan divisor.
// - Bits 7:6 select second fan divisor.
// - Slave address loads 001011 plus straps.
// - Bit four register: pin bit, 1000000 above.
// - Equal mode bits: interrupt above hot.
// - Default mode: read clears, conversions re-raise.
// - One-time mode: raise once above hot.
// - Then one interrupt below hysteresis only.
// - Then silent until hot again.
// - Comparator mode: raise above hot limit.
// - Comparator: read or below hot clears.
// - Temperature config resets to 01h.
// - Config bit 7 reads half degree.
// - Factory test register resets to zero.
// - Status bit 4 follows mode, read clears.
// - Mask bit blocks temperature interrupt.
// - Hot and hysteresis limits at 39h, 3Ah.
module mctir_regs
    import mctir_pkg::*;
#(
    parameter logic [7:0] HOT_RESET = 8'h50,
    parameter logic [7:0] HYST_RESET = 8'h4b,
    parameter int PRESC_W = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic conv_clk,
    input wire logic conv_reset,
    input wire logic conv_done,
    input wire logic [TEMP_W-1:0] conv_temp,
    input wire logic [3:0] voltage_id_inputs,
    input wire logic voltage_id_bit_four,
    input wire logic addr_strap_low,
    input wire logic addr_strap_high,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic mgmt_irq_n,
    output logic first_fan_tach_en,
    output logic second_fan_tach_en
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] pf;
        logic scl_q;
        logic sda_q;
        logic tog1;
        logic tog2;
        logic tog3;
        logic [TEMP_W-1:0] temp;
        logic [2:0] strap_cnt;
        logic [7:0] saddr;
        logic [1:0][1:0] div;
        logic [6:0] voltage_id_bit_four_hi;
        logic [6:0] tconf;
        logic [7:0] test;
        logic [7:0] mask1;
        logic [7:0] hot;
        logic [7:0] hyst;
        logic temp_flag;
        logic hot_act;
        logic otm_hot;
        logic irq_n;
        logic [1:0][PRESC_W-1:0] presc;
        logic [1:0] cnt_en;
        mctir_bus_type state;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic nack;
        logic sda_drv;
    } mctir_state_type;

    mctir_state_type r;
    mctir_state_type n;
    logic [TEMP_W-1:0] link_temp;
    logic link_tog;
    logic [PIN_COUNT-1:0] pins;
    logic [1:0] tmode;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic conv_ev;
    logic above;
    logic below;
    logic rd_clr;
    logic wr_en;
    logic set_t;
    logic clr_t;

    if (PRESC_W < 3) begin : g_check
        $error("PRESC_W must reach a divide by eight");
    end

    mctir_conv_link u_link (
        .conv_clk(conv_clk),
        .conv_reset(conv_reset),
        .conv_done(conv_done),
        .conv_temp(conv_temp),
        .temp_hold(link_temp),
        .temp_toggle(link_tog)
    );

    // ************************************************************
    // Decoding
    // ************************************************************
    function automatic logic [7:0] rd_byte(input mctir_state_type s);
        logic [7:0] v;
        v = 8'h00;
        case (s.ptr)
            OFF_TEST: v = s.test;
            OFF_TEMP_MSB: v = s.temp[TEMP_W-1:1];
            OFF_HOT: v = s.hot;
            OFF_HYST: v = s.hyst;
            OFF_STAT1: v = 8'(s.temp_flag) << STAT_TEMP_BIT;
            OFF_MASK1: v = s.mask1;
            OFF_VID: v = {s.div, s.pf[PIN_VID_LSB+3:PIN_VID_LSB]};
            OFF_SADDR: v = s.saddr;
            OFF_VOLTAGE_ID_BIT_FOUR: v = {s.voltage_id_bit_four_hi, s.pf[PIN_VID_LSB+4]};
            OFF_TCONF: v = {s.temp[0], s.tconf};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic [PRESC_W-1:0] div_mask(input logic [1:0] sel);
        return PRESC_W'((1 << sel) - 1);
    endfunction

    assign pins = {sda_in, scl_in, addr_strap_high, addr_strap_low,
                   voltage_id_bit_four, voltage_id_inputs};
    assign tmode = r.tconf[1:0];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n = r;
        rd_clr = 1'b0;
        wr_en = 1'b0;
        set_t = 1'b0;
        // Pins pass three flops; a change counts once the last two agree.
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.pf = (r.s3 & ~(r.s2 ^ r.s3)) | (r.pf & (r.s2 ^ r.s3));
        n.scl_q = r.pf[PIN_SCL];
        n.sda_q = r.pf[PIN_SDA];
        scl_rise = r.pf[PIN_SCL] & ~r.scl_q;
        scl_fall = ~r.pf[PIN_SCL] & r.scl_q;
        start_c = r.pf[PIN_SCL] & r.scl_q & r.sda_q & ~r.pf[PIN_SDA];
        stop_c = r.pf[PIN_SCL] & r.scl_q & ~r.sda_q & r.pf[PIN_SDA];

        // Conversion results arrive by toggle from the conversion clock.
        n.tog1 = link_tog;
        n.tog2 = r.tog1;
        n.tog3 = r.tog2;
        conv_ev = r.tog2 ^ r.tog3;
        above = $signed(link_temp[TEMP_W-1:1]) > $signed(r.hot);
        below = $signed(link_temp[TEMP_W-1:1]) < $signed(r.hyst);
        if (conv_ev) begin
            n.temp = link_temp;
        end

        // Address straps are taken once the pin filter has settled.
        if (r.strap_cnt != 3'h0) begin
            n.strap_cnt = r.strap_cnt - 3'h1;
        end
        if (r.strap_cnt == 3'h1) begin
            n.saddr = {SADDR_FIXED, r.pf[PIN_STRAP_HIGH], r.pf[PIN_STRAP_LOW]};
        end

        // 2-wire slave: address, pointer, then data bytes.
        if (start_c) begin
            n.state = BUS_ADDR;
            n.bitcnt = 4'h0;
            n.sda_drv = 1'b0;
        end else if (stop_c) begin
            n.state = BUS_IDLE;
            n.sda_drv = 1'b0;
        end else begin
            unique case (r.state)
                BUS_IDLE: begin
                    n.sda_drv = 1'b0;
                end
                BUS_ADDR, BUS_PTR, BUS_WR: begin
                    if (scl_rise) begin
                        n.sh = {r.sh[6:0], r.pf[PIN_SDA]};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (scl_fall && r.bitcnt == BYTE_BITS) begin
                        n.sda_drv = 1'b1;
                        n.bitcnt = 4'h0;
                        if (r.state == BUS_ADDR) begin
                            if (r.sh[7:1] == r.saddr[6:0]) begin
                                n.rw = r.sh[0];
                                n.state = BUS_AACK;
                            end else begin
                                n.sda_drv = 1'b0;
                                n.state = BUS_IDLE;
                            end
                        end else if (r.state == BUS_PTR) begin
                            n.ptr = r.sh;
                            n.state = BUS_PACK;
                        end else begin
                            wr_en = 1'b1;
                            n.ptr = r.ptr + 8'h01;
                            n.state = BUS_WACK;
                        end
                    end
                end
                BUS_AACK, BUS_PACK, BUS_WACK, BUS_RACK: begin
                    if (scl_rise) begin
                        n.nack = r.pf[PIN_SDA];
                    end
                    if (scl_fall) begin
                        n.sda_drv = 1'b0;
                        n.bitcnt = 4'h0;
                        if ((r.state == BUS_AACK && r.rw) || (r.state == BUS_RACK && !r.nack)) begin
                            n.sh = rd_byte(r);
                            n.sda_drv = ~n.sh[7];
                            rd_clr = (r.ptr == OFF_STAT1);
                            n.ptr = r.ptr + 8'h01;
                            n.state = BUS_RD;
                        end else if (r.state == BUS_RACK) begin
                            n.state = BUS_IDLE;
                        end else if (r.state == BUS_AACK) begin
                            n.state = BUS_PTR;
                        end else begin
                            n.state = BUS_WR;
                        end
                    end
                end
                BUS_RD: begin
                    if (scl_rise) begin
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (r.bitcnt == BYTE_BITS) begin
                            n.sda_drv = 1'b0;
                            n.bitcnt = 4'h0;
                            n.state = BUS_RACK;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.sda_drv = ~r.sh[6];
                        end
                    end
                end
                default: begin
                    n.state = BUS_IDLE;
                    n.sda_drv = 1'b0;
                end
            endcase
        end

        // Register writes keep only the read-write fields.
        if (wr_en) begin
            case (r.ptr)
                OFF_TEST: n.test = r.sh;
                OFF_VID: n.div = r.sh[7:4];
                OFF_SADDR: n.saddr = r.sh;
                OFF_VOLTAGE_ID_BIT_FOUR: n.voltage_id_bit_four_hi = r.sh[7:1];
                OFF_TCONF: n.tconf = r.sh[6:0];
                OFF_MASK1: n.mask1 = r.sh;
                OFF_HOT: n.hot = r.sh;
                OFF_HYST: n.hyst = r.sh;
                default: n.test = r.test;
            endcase
        end

        // Temperature interrupt; a set in the read cycle wins over the clear.
        clr_t = rd_clr;
        if (conv_ev) begin
            unique case (tmode)
                TMODE_ONCE: begin
                    if (!r.otm_hot && above) begin
                        set_t = 1'b1;
                        n.otm_hot = 1'b1;
                    end else if (r.otm_hot && below) begin
                        set_t = 1'b1;
                        n.otm_hot = 1'b0;
                    end
                end
                TMODE_COMP: begin
                    set_t = above;
                    clr_t = rd_clr | ~above;
                end
                default: begin
                    n.hot_act = above | (r.hot_act & ~below);
                    set_t = n.hot_act;
                end
            endcase
        end
        n.temp_flag = set_t | (r.temp_flag & ~clr_t);
        n.irq_n = ~(n.temp_flag & ~n.mask1[STAT_TEMP_BIT]);

        // Fan count enables pulse once every one, two, four or eight cycles.
        for (int i = 0; i < 2; i++) begin
            n.presc[i] = r.presc[i] + PRESC_W'(1);
            n.cnt_en[i] = (r.presc[i] & div_mask(r.div[i])) == '0;
        end

        if (reset) begin
            n = '0;
            n.s1 = '1;
            n.s2 = '1;
            n.s3 = '1;
            n.pf = '1;
            n.scl_q = 1'b1;
            n.sda_q = 1'b1;
            n.state = BUS_IDLE;
            n.strap_cnt = STRAP_SETTLE;
            n.saddr = {SADDR_FIXED, 2'b00};
            n.voltage_id_bit_four_hi = RST_VOLTAGE_ID_BIT_FOUR_HI;
            n.tconf = RST_TCONF;
            n.test = RST_TEST;
            n.mask1 = RST_MASK1;
            n.hot = HOT_RESET;
            n.hyst = HYST_RESET;
            n.irq_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        r <= n;
    end

    assign sda_out = 1'b0;
    assign sda_oe = r.sda_drv;
    assign mgmt_irq_n = r.irq_n;
    assign first_fan_tach_en = r.cnt_en[0];
    assign second_fan_tach_en = r.cnt_en[1];

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_conv_above;
        conv_ev && above;
    endsequence

    sequence s_once_waiting_low;
        tmode == TMODE_ONCE && r.otm_hot && !r.temp_flag;
    endsequence

    a_def_set: assert property (
        (tmode != TMODE_ONCE && tmode != TMODE_COMP) ##0 s_conv_above |=> r.temp_flag)
        else $error("default mode missed a hot conversion");

    a_def_rearm: assert property (
        (tmode != TMODE_ONCE && tmode != TMODE_COMP && r.hot_act && conv_ev && !below)
        |=> r.temp_flag && r.hot_act)
        else $error("default mode did not re-raise above hysteresis");

    a_once_trip: assert property (
        (tmode == TMODE_ONCE && !r.otm_hot) ##0 s_conv_above |=> r.temp_flag && r.otm_hot)
        else $error("one-time mode missed the hot crossing");

    a_once_quiet: assert property (
        s_once_waiting_low ##0 (!conv_ev || !below) |=> !r.temp_flag && r.otm_hot)
        else $error("one-time mode raised before hysteresis");

    a_comp_set: assert property (
        tmode == TMODE_COMP ##0 s_conv_above |=> r.temp_flag ##1 (r.temp_flag || $past(rd_clr)))
        else $error("comparator mode missed a hot conversion");

    a_comp_drop: assert property (
        (tmode == TMODE_COMP && conv_ev && !above) |=> !r.temp_flag)
        else $error("comparator mode kept flag below hot limit");

    a_read_clear: assert property (
        (rd_clr && !conv_ev) |=> !r.temp_flag ##1 (!r.temp_flag || $past(conv_ev)))
        else $error("status read did not clear the flag");

    a_irq_gate: assert property (
        mgmt_irq_n == !(r.temp_flag && !r.mask1[STAT_TEMP_BIT]))
        else $error("interrupt output disagrees with flag and mask");

    a_strap_load: assert property (
        r.strap_cnt == 3'h1 |=> r.saddr == {SADDR_FIXED, $past(r.pf[PIN_STRAP_HIGH]),
                                            $past(r.pf[PIN_STRAP_LOW])})
        else $error("slave address not loaded from straps");

    a_vid_write: assert property (
        (wr_en && r.ptr == OFF_VID) |=> r.div == $past(r.sh[7:4]))
        else $error("divisor fields not written");

    a_reset_vals: assert property (
        $past(reset) |-> r.tconf == RST_TCONF && r.test == RST_TEST && r.voltage_id_bit_four_hi == RST_VOLTAGE_ID_BIT_FOUR_HI)
        else $error("reset values wrong");

    a_fan_div: assert property (
        (!$past(reset) && $past(r.div[0]) == 2'b00) |-> first_fan_tach_en)
        else $error("divide by one did not enable every cycle");

endmodule // mctir_regs

// File: design/mctir_pkg.sv
// Register map, reset values, pin order and bus states of the monitor configuration block.
package mctir_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_TEST = 8'h15;
    localparam logic [7:0] OFF_TEMP_MSB = 8'h27;
    localparam logic [7:0] OFF_HOT = 8'h39;
    localparam logic [7:0] OFF_HYST = 8'h3a;
    localparam logic [7:0] OFF_STAT1 = 8'h41;
    localparam logic [7:0] OFF_MASK1 = 8'h43;
    localparam logic [7:0] OFF_VID = 8'h47;
    localparam logic [7:0] OFF_SADDR = 8'h48;
    localparam logic [7:0] OFF_VOLTAGE_ID_BIT_FOUR = 8'h49;
    localparam logic [7:0] OFF_TCONF = 8'h4b;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int STAT_TEMP_BIT = 4;
    localparam logic [7:0] RST_TEST = 8'h00;
    localparam logic [7:0] RST_MASK1 = 8'h00;
    localparam logic [6:0] RST_TCONF = 7'h01;
    localparam logic [6:0] RST_VOLTAGE_ID_BIT_FOUR_HI = 7'h40;
    localparam logic [5:0] SADDR_FIXED = 6'h0b;
    localparam logic [1:0] TMODE_ONCE = 2'h1;
    localparam logic [1:0] TMODE_COMP = 2'h2;

    // ************************************************************
    // Pin sampling order and timing counts
    // ************************************************************
    localparam int PIN_VID_LSB = 0;
    localparam int PIN_STRAP_LOW = 5;
    localparam int PIN_STRAP_HIGH = 6;
    localparam int PIN_SCL = 7;
    localparam int PIN_SDA = 8;
    localparam int PIN_COUNT = 9;
    localparam int TEMP_W = 9;
    localparam logic [2:0] STRAP_SETTLE = 3'h5;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ************************************************************
    // 2-wire slave states
    // ************************************************************
    typedef enum logic [8:0] {
        BUS_IDLE = 9'h001,
        BUS_ADDR = 9'h002,
        BUS_AACK = 9'h004,
        BUS_PTR = 9'h008,
        BUS_PACK = 9'h010,
        BUS_WR = 9'h020,
        BUS_WACK = 9'h040,
        BUS_RD = 9'h080,
        BUS_RACK = 9'h100
    } mctir_bus_type;

endpackage

// File: design/mctir_conv_link.sv
// Conversion-clock capture of each finished temperature result.
`timescale 1ns/1ns
module mctir_conv_link
    import mctir_pkg::*;
(
    input wire logic conv_clk,
    input wire logic conv_reset,
    input wire logic conv_done,
    input wire logic [TEMP_W-1:0] conv_temp,
    output logic [TEMP_W-1:0] temp_hold,
    output logic temp_toggle
);

    typedef struct packed {
        logic [TEMP_W-1:0] hold;
        logic tog;
    } mctir_link_type;

    mctir_link_type r;
    mctir_link_type n;

    // The held word stays still until the next conversion, so the register
    // side may take it once it has seen the toggle.
    always_comb begin
        n = r;
        if (conv_done) begin
            n.hold = conv_temp;
            n.tog = ~r.tog;
        end
        if (conv_reset) begin
            n = '0;
        end
    end

    always_ff @(posedge conv_clk) begin
        r <= n;
    end

    assign temp_hold = r.hold;
    assign temp_toggle = r.tog;

    a_link_toggle: assert property (
        @(posedge conv_clk) disable iff (conv_reset)
        conv_done |=> (r.tog != $past(r.tog)) && (r.hold == $past(conv_temp)))
        else $error("conversion result not handed over");

endmodule // mctir_conv_link

// File: tb/mctir_host.sv
// Behavioural 2-wire bus controller that reaches the register block.
`timescale 1ns/1ns
module mctir_host
    import mctir_pkg::*;
(
    input wire logic clk,
    input wire logic sda,
    input wire logic [6:0] dev_addr,
    output logic scl,
    output logic sda_low
);
    localparam int HALF = 12;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data changes one cycle after the clock line falls, so the filter sees it settled.
    task automatic put_bit(input logic b);
        hold(1);
        sda_low = !b;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        hold(1);
        sda_low = 1'b0;
        hold(HALF);
        scl = 1'b1;
        hold(HALF / 2);
        b = sda;
        hold(HALF / 2);
        scl = 1'b0;
    endtask
    task automatic start();
        hold(1);
        sda_low = 1'b0;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sda_low = 1'b1;
        hold(HALF);
        scl = 1'b0;
    endtask
    task automatic stop();
        hold(1);
        sda_low = 1'b1;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sda_low = 1'b0;
        hold(HALF);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        send({dev_addr, 1'b0}, k0);
        send(a, k1);
        send(d, k2);
        stop();
        ok = k0 && k1 && k2;
    endtask
    // A single byte is read, then refused with a high acknowledge bit.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        send({dev_addr, 1'b0}, k0);
        send(a, k1);
        start();
        send({dev_addr, 1'b1}, k2);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(1'b1);
        stop();
        ok = k0 && k1 && k2;
    endtask
endmodule // mctir_host

// File: tb/monitor_config_temp_irq_regs_tb_top.sv
// Self-checking bench of the monitor configuration register block.
`timescale 1ns/1ns
module monitor_config_temp_irq_regs_tb_top
    import mctir_pkg::*;
;
    logic clk, reset, conv_clk, conv_reset, conv_done, voltage_id_bit_four;
    logic addr_strap_low, addr_strap_high, scl_in, sda_in, sda_out, sda_oe, mgmt_irq_n;
    logic first_fan_tach_en, second_fan_tach_en, host_low;
    logic [8:0] conv_temp;
    logic [3:0] voltage_id_inputs;
    logic [6:0] dev;
    logic [7:0] m [logic [7:0]];
    logic [7:0] tl [8] = '{8'h19, 8'h1e, 8'h0f, 8'h05, 8'h0c, 8'h19, 8'h0f, 8'hfd};
    logic [7:0] al [10] = '{OFF_TEST, OFF_HOT, OFF_HYST, OFF_MASK1, OFF_VID, OFF_VOLTAGE_ID_BIT_FOUR,
        OFF_TCONF, OFF_TEMP_MSB, 8'h50, OFF_SADDR};
    logic [8:0] m_temp;
    logic m_flag, m_arm, ok;
    int errors = 0, cmp_count = 0, seed = 6, mode, r, c1, c2;
    assign sda_in = !host_low && !(sda_oe && !sda_out);
    mctir_regs #(.HOT_RESET(8'h50), .HYST_RESET(8'h4b), .PRESC_W(3)) dut (.clk(clk),
        .reset(reset), .conv_clk(conv_clk), .conv_reset(conv_reset), .conv_done(conv_done),
        .conv_temp(conv_temp), .voltage_id_inputs(voltage_id_inputs),
        .voltage_id_bit_four(voltage_id_bit_four), .addr_strap_low(addr_strap_low),
        .addr_strap_high(addr_strap_high), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .mgmt_irq_n(mgmt_irq_n),
        .first_fan_tach_en(first_fan_tach_en), .second_fan_tach_en(second_fan_tach_en));
    mctir_host host (.clk(clk), .sda(sda_in), .dev_addr(dev), .scl(scl_in),
        .sda_low(host_low));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        conv_clk = 1'b0;
        #7;
        forever #6 conv_clk = ~conv_clk;
    end
    task automatic report_and_stop();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // ************************************************************
    // Reference model of the register map
    // ************************************************************
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        logic [7:0] v;
        v = m.exists(a) ? m[a] : 8'h00;
        case (a)
            OFF_VID: v = {v[7:4], voltage_id_inputs};
            OFF_VOLTAGE_ID_BIT_FOUR: v = {v[7:1], voltage_id_bit_four};
            OFF_TCONF: v = {m_temp[0], v[6:0]};
            OFF_TEMP_MSB: v = m_temp[8:1];
            OFF_STAT1: v = {3'h0, m_flag, 4'h0};
            default: ;
        endcase
        return v;
    endfunction
    task automatic do_reset();
        reset = 1'b1;
        conv_reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        conv_reset = 1'b0;
        repeat (12) @(negedge clk);
        m.delete();
        m[OFF_TEST] = RST_TEST;
        m[OFF_HOT] = 8'h50;
        m[OFF_HYST] = 8'h4b;
        m[OFF_MASK1] = RST_MASK1;
        m[OFF_VID] = 8'h00;
        m[OFF_SADDR] = {SADDR_FIXED, addr_strap_high, addr_strap_low};
        m[OFF_VOLTAGE_ID_BIT_FOUR] = {RST_VOLTAGE_ID_BIT_FOUR_HI, 1'b0};
        m[OFF_TCONF] = {1'b0, RST_TCONF};
        m_temp = 9'h000;
        m_flag = 1'b0;
        m_arm = 1'b0;
        dev = m[OFF_SADDR][6:0];
    endtask
    task automatic mw(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d, ok);
        chk("write ack", 8'h01, {7'h0, ok});
        if (m.exists(a))
            m[a] = d;
        if (a == OFF_SADDR)
            dev = d[6:0];
    endtask
    task automatic mr(input logic [7:0] a);
        logic [7:0] d;
        host.rd(a, d, ok);
        chk("read ack", 8'h01, {7'h0, ok});
        chk($sformatf("reg %h", a), exp_rd(a), d);
        if (a == OFF_STAT1)
            m_flag = 1'b0;
    endtask
    task automatic conv(input logic [7:0] t);
        logic signed [7:0] s, h, y;
        r = $random(seed);
        @(negedge conv_clk);
        conv_temp = {t, r[0]};
        conv_done = 1'b1;
        @(negedge conv_clk);
        conv_done = 1'b0;
        repeat (12) @(negedge clk);
        m_temp = {t, r[0]};
        s = t;
        h = m[OFF_HOT];
        y = m[OFF_HYST];
        if (mode == 1) begin
            if (!m_arm && s > h) begin
                m_flag = 1'b1;
                m_arm = 1'b1;
            end else if (m_arm && s < y) begin
                m_flag = 1'b1;
                m_arm = 1'b0;
            end
        end else if (mode == 2)
            m_flag = s > h;
        else begin
            m_arm = s > h ? 1'b1 : (s < y ? 1'b0 : m_arm);
            m_flag = m_flag || m_arm;
        end
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        conv_done = 1'b0;
        conv_temp = 9'h000;
        r = $random(seed);
        {voltage_id_inputs, voltage_id_bit_four, addr_strap_low, addr_strap_high} = r[6:0];
        do_reset();
        // A foreign address must get no acknowledge and must leave the test register alone.
        dev = ~dev;
        host.wr(OFF_TEST, 8'ha5, ok);
        chk("foreign address ack", 8'h00, {7'h0, ok});
        dev = m[OFF_SADDR][6:0];
        foreach (al[i])
            mr(al[i]);
        foreach (al[i]) begin
            r = $random(seed);
            mw(al[i], r[7:0]);
            mr(al[i]);
        end
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            voltage_id_inputs = r[3:0];
            mw(OFF_VID, {2'(3 - k), 2'(k), 4'h0});
            c1 = 0;
            c2 = 0;
            repeat (32) begin
                @(negedge clk);
                c1 += int'(first_fan_tach_en);
                c2 += int'(second_fan_tach_en);
            end
            chk("first_fan_tach pulses", 8'(32 >> k), c1[7:0]);
            chk("second_fan_tach pulses", 8'(32 >> (3 - k)), c2[7:0]);
            mr(OFF_VID);
        end
        for (int md = 0; md < 4; md++) begin
            do_reset();
            mw(OFF_HOT, 8'h14);
            mw(OFF_HYST, 8'h0a);
            mw(OFF_MASK1, {3'h0, 1'(md == 3), 4'h0});
            r = $random(seed);
            mw(OFF_TCONF, {r[7:2], 2'(md)});
            mode = md;
            for (int i = 0; i < 8; i++) begin
                conv(tl[i]);
                chk("irq", {7'h0, !(m_flag && !m[OFF_MASK1][4])}, {7'h0, mgmt_irq_n});
                if (i % 2 == 0) begin
                    mr(OFF_STAT1);
                    chk("irq after read", 8'h01, {7'h0, mgmt_irq_n});
                end
            end
            mr(OFF_TEMP_MSB);
            mr(OFF_TCONF);
        end
        report_and_stop();
    end
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule // monitor_config_temp_irq_regs_tb_top
